// [include/tlic_pkg.sv]
/*
 Package of the two-level interrupt mask controller: register offsets,
 field positions, reset values and the source map.
 Assumes a 32-bit register port with byte addresses.
*/
package tlic_pkg;
   localparam int TLIC_WIDTH = 32;
   localparam int TLIC_ADDR_W = 32;
   // Register byte addresses
   localparam logic [31:0] TLIC_NORM_STATUS = 32'hFFFF0000;
   localparam logic [31:0] TLIC_NORM_RAW = 32'hFFFF0004;
   localparam logic [31:0] TLIC_NORM_ENABLE = 32'hFFFF0008;
   localparam logic [31:0] TLIC_NORM_CLEAR = 32'hFFFF000C;
   localparam logic [31:0] TLIC_SWI_CONFIG = 32'hFFFF0010;
   localparam logic [31:0] TLIC_FAST_STATUS = 32'hFFFF0100;
   localparam logic [31:0] TLIC_FAST_RAW = 32'hFFFF0104;
   localparam logic [31:0] TLIC_FAST_ENABLE = 32'hFFFF0108;
   localparam logic [31:0] TLIC_FAST_CLEAR = 32'hFFFF010C;
   // Field positions
   localparam int TLIC_FAST_SRC_BIT = 0;
   localparam int TLIC_SWI_SRC_BIT = 1;
   localparam int TLIC_SWI_NORM_BIT = 1;
   localparam int TLIC_SWI_FAST_BIT = 2;
   localparam int TLIC_MOTOR_BIT = 23;
   // Reset values
   localparam logic [31:0] TLIC_ENABLE_RST = 32'h00000000;
   localparam logic [31:0] TLIC_READ_RST = 32'h00000000;
   localparam logic TLIC_SWI_RST = 1'h0;
endpackage : tlic_pkg

// [include/tlic_level_if.sv]
/*
 Interface carrying one level's raw sources, enables and status between
 the controller top and its level module.
 Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface tlic_level_if #(parameter int WIDTH = 32);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] enable;
   logic [WIDTH-1:0] status;
   logic request;
   modport ctrl (output raw, output enable, input status, input request);
   modport level (input raw, input enable, output status, output request);
endinterface : tlic_level_if

// [logic/tlic_level.sv]
/*
 One interrupt level: masks the raw lines with the enables and ORs the
 result from bit FIRST_BIT upward into the core request.
 Assumes raw and enable come from logic on the same clock.
*/
`timescale 1ns/1ps
module tlic_level
   import tlic_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int FIRST_BIT = 0
) (
   tlic_level_if.level lvl
);
   // Level request gathers chosen bits only
   wire [WIDTH-1:0] reqBits;
   assign lvl.status = lvl.raw & lvl.enable;
   assign reqBits = lvl.status >> FIRST_BIT;
   assign lvl.request = |reqBits;
   // Request slice must start inside the word
   if (FIRST_BIT < 0 || FIRST_BIT >= WIDTH) begin : g_firstBitCheck
      $error("tlic_level: FIRST_BIT out of range");
   end
endmodule : tlic_level

// [logic/tlic_top.sv]
/*
 Two-level interrupt mask controller: normal and fast request outputs,
 enable and clear registers, programmed interrupts.
 Assumes a one-cycle register port and sources synchronous to core_clk.
*/
`timescale 1ns/1ps
module tlic_top
   import tlic_pkg::*;
#(
   parameter int WIDTH = 32
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [TLIC_ADDR_W-1:0] regAddr,
   input wire logic [WIDTH-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [WIDTH-1:0] regRdata,
   input wire logic [WIDTH-1:0] normalSources,
   input wire logic [WIDTH-1:0] fastSources,
   output logic normalRequest,
   output logic fastRequest
);
   // Register map and bit positions assume a 32-bit word
   if (WIDTH != TLIC_WIDTH) begin : g_widthCheck
      $error("tlic_top: WIDTH must be 32");
   end

   logic [WIDTH-1:0] normEnable;
   logic [WIDTH-1:0] fastEnable;
   logic swiNormal;
   logic swiFast;
   logic [WIDTH-1:0] next_normEnable;
   logic [WIDTH-1:0] next_fastEnable;

   // Address decode of write strobes
   wire wrNormEn = regWrite && regAddr == TLIC_NORM_ENABLE;
   wire wrNormClr = regWrite && regAddr == TLIC_NORM_CLEAR;
   wire wrFastEn = regWrite && regAddr == TLIC_FAST_ENABLE;
   wire wrFastClr = regWrite && regAddr == TLIC_FAST_CLEAR;
   wire wrSwi = regWrite && regAddr == TLIC_SWI_CONFIG;

   tlic_level_if #(.WIDTH(WIDTH)) normIf ();
   tlic_level_if #(.WIDTH(WIDTH)) fastIf ();

   // Fast request is formed first; it loops back as bit 0 source
   wire fastOr = fastIf.request;

   // Raw views: line inputs, fast source at bit 0, programmed at bit 1.
   // Line bit 23 carries trip on normal, sync on fast by wiring.
   wire [WIDTH-1:0] normRawLines;
   wire [WIDTH-1:0] fastRawLines;
   assign normRawLines = normalSources;
   assign fastRawLines = fastSources;
   wire [WIDTH-1:0] normSwiMask = {{(WIDTH-1){1'b0}}, swiNormal}
      << TLIC_SWI_SRC_BIT;
   wire [WIDTH-1:0] fastSwiMask = {{(WIDTH-1){1'b0}}, swiFast}
      << TLIC_SWI_SRC_BIT;
   wire [WIDTH-1:0] fastBitMask = {{(WIDTH-1){1'b0}}, fastOr}
      << TLIC_FAST_SRC_BIT;
   // Bits 0 and 1 are internal; external lines there are ignored
   wire [WIDTH-1:0] lineMask = ~(32'h00000003);
   wire [WIDTH-1:0] normRaw = (normRawLines & lineMask) | fastBitMask
      | normSwiMask;
   wire [WIDTH-1:0] fastRaw = (fastRawLines & lineMask) | fastSwiMask;
   // Fast bit 0 is shown on read but never feeds its own OR
   wire [WIDTH-1:0] fastRawRead = fastRaw | fastBitMask;

   // Programmed bit forced into status regardless of enable
   wire [WIDTH-1:0] normStatus = normIf.status | normSwiMask;
   wire [WIDTH-1:0] fastStatus = fastIf.status | fastSwiMask
      | fastBitMask;

   assign normIf.raw = normRaw;
   assign normIf.enable = normEnable | normSwiMask;
   assign fastIf.raw = fastRaw;
   assign fastIf.enable = fastEnable | fastSwiMask;

   tlic_level #(.WIDTH(WIDTH), .FIRST_BIT(0)) normLevel (
      .lvl(normIf.level)
   );
   tlic_level #(.WIDTH(WIDTH), .FIRST_BIT(1)) fastLevel (
      .lvl(fastIf.level)
   );

   // Request outputs are plain levels; no vector or priority logic
   assign normalRequest = normIf.request;
   assign fastRequest = fastOr;

   // Enables gain ones on set writes, lose them on clear writes and on set writes to the other level
   always_comb begin
      next_normEnable = normEnable;
      next_fastEnable = fastEnable;
      if (wrNormEn) begin
         next_normEnable = normEnable | regWdata;
         next_fastEnable = fastEnable & ~regWdata;
      end
      if (wrFastEn) begin
         next_fastEnable = fastEnable | regWdata;
         next_normEnable = normEnable & ~regWdata;
      end
      if (wrNormClr) begin
         next_normEnable = normEnable & ~regWdata;
      end
      if (wrFastClr) begin
         next_fastEnable = fastEnable & ~regWdata;
      end
   end

   // Enable and programmed-interrupt state
   always_ff @(posedge core_clk) begin
      if (reset) begin
         normEnable <= TLIC_ENABLE_RST;
         fastEnable <= TLIC_ENABLE_RST;
         swiNormal <= TLIC_SWI_RST;
         swiFast <= TLIC_SWI_RST;
      end else begin
         normEnable <= next_normEnable;
         fastEnable <= next_fastEnable;
         if (wrSwi) begin
            swiNormal <= regWdata[TLIC_SWI_NORM_BIT];
            swiFast <= regWdata[TLIC_SWI_FAST_BIT];
         end
      end
   end

   // Read mux; write-only and unmapped addresses read zero
   logic [WIDTH-1:0] readMux;
   always_comb begin
      unique case (regAddr)
         TLIC_NORM_STATUS: readMux = normStatus;
         TLIC_NORM_RAW: readMux = normRaw;
         TLIC_NORM_ENABLE: readMux = normEnable;
         TLIC_FAST_STATUS: readMux = fastStatus;
         TLIC_FAST_RAW: readMux = fastRawRead;
         TLIC_FAST_ENABLE: readMux = fastEnable;
         default: readMux = TLIC_READ_RST;
      endcase
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk) begin
      if (reset) begin
         regRdata <= TLIC_READ_RST;
      end else begin
         regRdata <= regRead ? readMux : TLIC_READ_RST;
      end
   end

   // Helper flags for assertions
   logic pastRead;
   logic [WIDTH-1:0] pastMux;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pastRead <= 1'b0;
         pastMux <= TLIC_READ_RST;
      end else begin
         pastRead <= regRead;
         pastMux <= readMux;
      end
   end

   // Every check below runs on core_clk and sleeps during reset
   default clocking assertClk @(posedge core_clk);
   endclocking
   default disable iff (reset);

   // Normal request is the OR of every masked normal line
   AST_NORM_REQ: assert property (
      normalRequest == |(normRaw & (normEnable | normSwiMask)))
      else $error("normal request not OR of masked sources");

   // Requests fall once every status bit is clear
   AST_IDLE: assert property (
      (normStatus == {WIDTH{1'b0}} |-> !normalRequest)
      and (fastStatus[WIDTH-1:1] == {(WIDTH-1){1'b0}} |-> !fastRequest))
      else $error("request high with no status bit set");

   // Status shows every enabled asserted source at once
   AST_NORM_STATUS: assert property (
      normStatus == ((normRaw & normEnable) | normSwiMask))
      else $error("normal status not raw AND enable");

   AST_FAST_STATUS: assert property (
      fastStatus[WIDTH-1:2] == (fastRaw[WIDTH-1:2] & fastEnable[WIDTH-1:2]))
      else $error("fast status not raw AND enable");

   // A masked line never reaches status; programmed bit aside
   AST_MASKED: assert property (
      (normStatus & ~normEnable & ~normSwiMask) == {WIDTH{1'b0}}
      && (fastStatus[WIDTH-1:1] & ~fastEnable[WIDTH-1:1]
         & ~fastSwiMask[WIDTH-1:1]) == {(WIDTH-1){1'b0}})
      else $error("masked source reached status");

   // Raw views follow the lines whatever the masks say
   AST_RAW: assert property (
      normRaw[WIDTH-1:2] == normalSources[WIDTH-1:2])
      else $error("raw mirror wrong");

   AST_FAST_RAW: assert property (
      fastRawRead[WIDTH-1:2] == fastSources[WIDTH-1:2])
      else $error("fast raw mirror wrong");

   // Shared position: trip on the normal side, sync on the fast side
   AST_MOTOR: assert property (
      normRaw[TLIC_MOTOR_BIT] == normalSources[TLIC_MOTOR_BIT]
      && fastRaw[TLIC_MOTOR_BIT] == fastSources[TLIC_MOTOR_BIT])
      else $error("motor event bit not carried on both levels");

   // Fast OR skips bit 0, else the fast source would latch itself
   AST_FAST_REQ: assert property (
      fastRequest == |(fastRaw[WIDTH-1:1]
         & (fastEnable[WIDTH-1:1] | fastSwiMask[WIDTH-1:1])))
      else $error("fast request wrong");

   // Bit 0 of both raw views and fast status is the fast request
   AST_FAST_BIT0: assert property (
      normRaw[0] == fastRequest && fastStatus[0] == fastRequest
      && fastRawRead[0] == fastRequest)
      else $error("bit 0 does not follow fast request");

   // No position is ever enabled at both levels
   AST_EXCLUSIVE: assert property (
      (normEnable & fastEnable) == {WIDTH{1'b0}})
      else $error("source enabled at both levels");

   // A set at one level drops the same bits at the other
   AST_SWAP_NORM: assert property (
      wrNormEn |=> (fastEnable & $past(regWdata)) == {WIDTH{1'b0}})
      else $error("normal set left fast bits enabled");

   AST_SWAP_FAST: assert property (
      wrFastEn |=> (normEnable & $past(regWdata)) == {WIDTH{1'b0}})
      else $error("fast set left normal bits enabled");

   // A set write enables every bit written as one
   AST_NORM_SET: assert property (
      wrNormEn |=> (normEnable & $past(regWdata)) == $past(regWdata))
      else $error("normal set did not enable");

   AST_FAST_SET: assert property (
      wrFastEn |=> (fastEnable & $past(regWdata)) == $past(regWdata))
      else $error("fast set did not enable");

   // Zeros in a set write never drop an enable
   AST_ZERO_KEEP: assert property (
      (wrNormEn && regWdata == {WIDTH{1'b0}} && !wrFastEn)
         |=> normEnable == $past(normEnable))
      else $error("zero write dropped normal enables");

   AST_FAST_KEEP: assert property (
      wrFastEn |=> (fastEnable & $past(fastEnable)) == $past(fastEnable))
      else $error("fast set write dropped fast enables");

   // Clear drops the written ones and nothing else
   AST_CLEAR: assert property (
      wrNormClr |=> (normEnable & $past(regWdata)) == {WIDTH{1'b0}}
         && (normEnable | $past(regWdata)) ==
            ($past(normEnable) | $past(regWdata)))
      else $error("normal clear wrong");

   AST_FAST_CLEAR: assert property (
      wrFastClr |=> (fastEnable & $past(regWdata)) == {WIDTH{1'b0}}
         && (fastEnable | $past(regWdata)) ==
            ($past(fastEnable) | $past(regWdata)))
      else $error("fast clear failed");

   // Without an enable or clear write both masks hold
   AST_QUIET: assert property (
      !(wrNormEn || wrNormClr || wrFastEn || wrFastClr)
         |=> $stable(normEnable) && $stable(fastEnable))
      else $error("enables moved without a write");

   // Programmed bits set and clear with the config write
   AST_SWI_NORM: assert property (
      wrSwi && regWdata[1] |=> normStatus[1] && normalRequest)
      else $error("programmed normal interrupt missing");

   AST_SWI_NORM_OFF: assert property (
      wrSwi && !regWdata[1] |=> !normRaw[1] && !normStatus[1])
      else $error("programmed normal interrupt stuck");

   AST_SWI_FAST: assert property (
      wrSwi && regWdata[2] |=> fastStatus[1] && fastRequest)
      else $error("programmed fast interrupt missing");

   AST_SWI_FAST_OFF: assert property (
      wrSwi && !regWdata[2] |=> !fastRaw[1] && !fastStatus[1])
      else $error("programmed fast interrupt stuck");

   // A pending programmed bit raises its request with no enable
   AST_SWI_BYPASS: assert property (
      (!swiNormal || normalRequest) && (!swiFast || fastRequest))
      else $error("programmed interrupt was masked");

   // Read data is the addressed view, one cycle late
   AST_RDATA: assert property (
      regRead |=> regRdata == $past(readMux))
      else $error("read data wrong");

   AST_RDATA_HELD: assert property (
      pastRead |-> regRdata == pastMux)
      else $error("read data not the captured view");

   // Idle cycles return zero so stale data is never re-read
   AST_RDATA_IDLE: assert property (
      !pastRead |-> regRdata == TLIC_READ_RST)
      else $error("read data not zero when idle");

   // Write-only registers read back as zero
   AST_WO_READ: assert property (
      regRead && (regAddr == TLIC_NORM_CLEAR
         || regAddr == TLIC_FAST_CLEAR || regAddr == TLIC_SWI_CONFIG)
         |=> regRdata == TLIC_READ_RST)
      else $error("write-only register read non-zero");

   // First edge out of reset: masks empty, both requests low
   AST_RESET: assert property (
      $fell(reset) |-> normEnable == TLIC_ENABLE_RST
         && fastEnable == TLIC_ENABLE_RST
         && !normalRequest && !fastRequest)
      else $error("state not cleared by reset");

   // Main scenarios to be seen at least once
   COV_NORM: cover property ($rose(normalRequest));
   COV_FAST: cover property ($rose(fastRequest));
   COV_SWAP: cover property (wrNormEn ##1 wrFastEn);
   COV_SWI: cover property (wrSwi && regWdata[2:1] == 2'h3);
   COV_BOTH: cover property (normalRequest && fastRequest);
endmodule : tlic_top

// [verif/tlic_src_model.sv]
/*
 Model of the peripheral and external request lines that feed the
 interrupt controller, normal and fast sides.
 Assumes the bench names the wanted line levels; lines move on core_clk.
*/
`timescale 1ns/1ps
module tlic_src_model
   import tlic_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [TLIC_WIDTH-1:0] wantNormal,
   input wire logic [TLIC_WIDTH-1:0] wantFast,
   output logic [TLIC_WIDTH-1:0] normalSources,
   output logic [TLIC_WIDTH-1:0] fastSources
);
   // Levels, registered copies of the wanted levels one cycle late, held
   // for as long as the bench keeps the wanted level
   // Bit 23 is trip on the normal side, sync on the fast side
   always_ff @(posedge core_clk) begin
      if (reset) begin
         normalSources <= 32'h00000000;
         fastSources <= 32'h00000000;
      end else begin
         normalSources <= wantNormal;
         fastSources <= wantFast;
      end
   end
endmodule : tlic_src_model

// [verif/two_level_interrupt_mask_controller_test.sv]
/*
 Self-checking bench of the two-level interrupt mask controller.
 Assumes the one-cycle register port and the source model beside it.
*/
`timescale 1ns/1ps
module two_level_interrupt_mask_controller_test;
   import tlic_pkg::*;
   logic core_clk, reset, regWrite, regRead, normalRequest, fastRequest;
   logic [31:0] regAddr, regWdata, regRdata, wantNormal, wantFast;
   logic [31:0] normalSources, fastSources;
   int failures = 0;
   int check_count = 0;
   tlic_top dut_u (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .normalSources(normalSources),
      .fastSources(fastSources), .normalRequest(normalRequest),
      .fastRequest(fastRequest));
   tlic_src_model src_u (.core_clk(core_clk), .reset(reset),
      .wantNormal(wantNormal), .wantFast(wantFast),
      .normalSources(normalSources), .fastSources(fastSources));
   // Free-running core clock, 50 ns
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   // One-cycle write; effect lands at the taking edge
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
      #1;
   endtask : wr
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask : rd
   task automatic src(input logic [31:0] n, input logic [31:0] f);
      @(posedge core_clk);
      wantNormal <= n;
      wantFast <= f;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : src
   function automatic logic [31:0] rq();
      return {30'h0, fastRequest, normalRequest};
   endfunction : rq
   task automatic t_reset();
      logic [31:0] d;
      rd(TLIC_NORM_STATUS, d); chk(d, 32'h00000000);
      rd(TLIC_NORM_ENABLE, d); chk(d, 32'h00000000);
      rd(TLIC_FAST_ENABLE, d); chk(d, 32'h00000000);
      rd(TLIC_NORM_CLEAR, d); chk(d, 32'h00000000);
      rd(32'hFFFF0020, d); chk(d, 32'h00000000);
   endtask : t_reset
   task automatic t_normal();
      logic [31:0] d;
      src(32'h00000220, 32'h00000000);
      chk(rq(), 32'h00000000);
      wr(TLIC_NORM_ENABLE, 32'h00000020);
      chk(rq(), 32'h00000001);
      rd(TLIC_NORM_STATUS, d); chk(d, 32'h00000020);
      rd(TLIC_NORM_RAW, d); chk(d, 32'h00000220);
      @(posedge core_clk);
      #1 chk(regRdata, 32'h00000000);
      wr(TLIC_NORM_ENABLE, 32'h00000000);
      rd(TLIC_NORM_ENABLE, d); chk(d, 32'h00000020);
      wr(TLIC_NORM_CLEAR, 32'h00000020);
      chk(rq(), 32'h00000000);
      src(32'h00000000, 32'h00000000);
      rd(TLIC_NORM_RAW, d); chk(d, 32'h00000000);
   endtask : t_normal
   task automatic t_fast();
      logic [31:0] d;
      src(32'h00000000, 32'h00800000);
      wr(TLIC_FAST_ENABLE, 32'h00800000);
      chk(rq(), 32'h00000002);
      rd(TLIC_FAST_STATUS, d); chk(d, 32'h00800001);
      rd(TLIC_NORM_RAW, d); chk(d, 32'h00000001);
      wr(TLIC_NORM_ENABLE, 32'h00000001);
      chk(rq(), 32'h00000003);
      wr(TLIC_FAST_ENABLE, 32'h00000000);
      chk(rq(), 32'h00000003);
      wr(TLIC_FAST_CLEAR, 32'h00800000);
      chk(rq(), 32'h00000000);
      wr(TLIC_NORM_CLEAR, 32'h00000001);
      src(32'h00000000, 32'h00000000);
   endtask : t_fast
   task automatic t_exclusive();
      logic [31:0] d;
      wr(TLIC_NORM_ENABLE, 32'h00000080);
      wr(TLIC_FAST_ENABLE, 32'h00000080);
      rd(TLIC_NORM_ENABLE, d); chk(d, 32'h00000000);
      rd(TLIC_FAST_ENABLE, d); chk(d, 32'h00000080);
      wr(TLIC_NORM_ENABLE, 32'h00000080);
      rd(TLIC_FAST_ENABLE, d); chk(d, 32'h00000000);
      wr(TLIC_NORM_CLEAR, 32'hFFFFFFFF);
      rd(TLIC_NORM_ENABLE, d); chk(d, 32'h00000000);
   endtask : t_exclusive
   task automatic t_soft();
      logic [31:0] d;
      wr(TLIC_SWI_CONFIG, 32'h00000002);
      chk(rq(), 32'h00000001);
      rd(TLIC_NORM_STATUS, d); chk(d, 32'h00000002);
      rd(TLIC_NORM_RAW, d); chk(d, 32'h00000002);
      wr(TLIC_SWI_CONFIG, 32'h00000004);
      chk(rq(), 32'h00000002);
      rd(TLIC_FAST_STATUS, d); chk(d, 32'h00000003);
      rd(TLIC_FAST_RAW, d); chk(d, 32'h00000003);
      wr(TLIC_SWI_CONFIG, 32'h00000000);
      chk(rq(), 32'h00000000);
   endtask : t_soft
   // Reset in mid-run drops enables and programmed bits
   task automatic t_rerun();
      logic [31:0] d;
      wr(TLIC_NORM_ENABLE, 32'h00000100);
      wr(TLIC_FAST_ENABLE, 32'h00000200);
      wr(TLIC_SWI_CONFIG, 32'h00000006);
      chk(rq(), 32'h00000003);
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      #1 chk(rq(), 32'h00000000);
      rd(TLIC_NORM_ENABLE, d); chk(d, 32'h00000000);
      rd(TLIC_FAST_ENABLE, d); chk(d, 32'h00000000);
      rd(TLIC_NORM_RAW, d); chk(d, 32'h00000000);
   endtask : t_rerun
   // Watchdog, well past the 115 or so cycles the tests take
   initial begin
      repeat (5000) @(posedge core_clk);
      failures++;
      end_sim();
   end
   // Main sequence, reset held 20 cycles
   initial begin
      reset = 1'b1;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 32'h00000000;
      regWdata = 32'h00000000;
      wantNormal = 32'h00000000;
      wantFast = 32'h00000000;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_normal();
      t_fast();
      t_exclusive();
      t_soft();
      t_rerun();
      end_sim();
   end
endmodule : two_level_interrupt_mask_controller_test
